// [bba_cfg.svh]
`ifndef BBA_CFG_SVH
`define BBA_CFG_SVH

////////////////////////////////////////////////////////////
// File register map
`define BBA_ADDR_TIMER 7'h01
`define BBA_ADDR_PTR_LOW 7'h02
`define BBA_ADDR_PORT 7'h05

////////////////////////////////////////////////////////////
// Reset values
`define BBA_W_RESET 8'h00
`define BBA_PTR_RESET 13'h0000
`define BBA_PORT_RESET 8'h00

////////////////////////////////////////////////////////////
// Instruction fields
`define BBA_CLASS_HI 13
`define BBA_CLASS_LO 12
`define BBA_CLASS_BYTE 2'h0
`define BBA_CLASS_BIT 2'h1
`define BBA_CLASS_LIT 2'h3
`define BBA_BSEL_HI 11
`define BBA_BSEL_LO 10
`define BBA_BSEL_CLR 2'h0
`define BBA_BSEL_SET 2'h1
`define BBA_BSEL_SKC 2'h2
`define BBA_BSEL_SKS 2'h3
`define BBA_IDX_HI 9
`define BBA_IDX_LO 7
`define BBA_ADDR_HI 6
`define BBA_ADDR_LO 0
`define BBA_DEST_POS 7
`define BBA_BYTE_OP_HI 11
`define BBA_BYTE_OP_LO 8
`define BBA_BYTE_ADD 4'h7
`define BBA_BYTE_AND 4'h5
`define BBA_LIT_ADD_HI 11
`define BBA_LIT_ADD_LO 9
`define BBA_LIT_ADD 3'h7
`define BBA_LIT_AND 4'h9
`define BBA_K_HI 7
`define BBA_K_LO 0

`endif

// [bba_pkg.sv]
package bba_pkg;

  typedef enum logic [3:0] {
    OP_IDLE_SLOT,
    OP_ADD_LITERAL,
    OP_AND_LITERAL,
    OP_ADD_FILE,
    OP_AND_FILE,
    OP_BIT_CLEAR,
    OP_BIT_SET,
    OP_SKIP_IF_CLEAR,
    OP_SKIP_IF_SET
  } bba_op_t;

  typedef enum logic {
    SLOT_RUN,
    SLOT_IDLE
  } bba_slot_t;

  typedef struct packed {
    bba_op_t op;
    logic dest_file;
    logic [2:0] bit_idx;
    logic [6:0] addr;
    logic [7:0] literal;
  } bba_decode_t;

  typedef struct packed {
    logic carry;
    logic half_carry_bit;
    logic zero;
  } bba_flags_t;

endpackage

// [bba_alu.sv]
`timescale 1ns/1ps
`include "bba_cfg.svh"

module bba_alu import bba_pkg::*; (
  input bba_op_t op,
  input logic [7:0] w_val,
  input logic [7:0] file_val,
  input logic [7:0] literal,
  input logic [2:0] bit_idx,
  input bba_flags_t flags_in,
  output logic [7:0] result,
  output bba_flags_t flags_out,
  output logic test_bit
);

  wire is_lit = (op == OP_ADD_LITERAL) || (op == OP_AND_LITERAL);
  wire [7:0] operand = is_lit ? literal : file_val;
  wire [8:0] sum9 = {1'b0, w_val} + {1'b0, operand};
  wire [4:0] half5 = {1'b0, w_val[3:0]} + {1'b0, operand[3:0]};
  wire [7:0] and8 = w_val & operand;
  wire [7:0] bit_mask = 8'h01 << bit_idx;

  assign test_bit = file_val[bit_idx];

  always_comb begin
    result = file_val;
    flags_out = flags_in;
    case (op)
      OP_ADD_LITERAL, OP_ADD_FILE: begin
        result = sum9[7:0];
        flags_out.carry = sum9[8];
        flags_out.half_carry_bit = half5[4];
        flags_out.zero = (sum9[7:0] == 8'h00);
      end
      OP_AND_LITERAL, OP_AND_FILE: begin
        result = and8;
        flags_out.zero = (and8 == 8'h00);
      end
      OP_BIT_CLEAR: begin
        result = file_val & ~bit_mask;
      end
      OP_BIT_SET: begin
        result = file_val | bit_mask;
      end
      default: begin
        result = file_val;
      end
    endcase
  end

endmodule // bba_alu

// [bba_core.sv]
`timescale 1ns/1ps
`include "bba_cfg.svh"

module bba_core import bba_pkg::*; (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic [13:0] INSTR,
  input wire logic [7:0] PIN_IN,
  input wire logic PRESC_ON_TIMER,
  output logic [12:0] INSTR_ADDR,
  output logic [7:0] W_OUT,
  output bba_flags_t FLAGS,
  output logic [7:0] PORT_LATCH,
  output logic PRESC_CLR,
  output logic IDLE_SLOT
);

  ////////////////////////////////////////////////////////////
  // Decode
  function automatic bba_decode_t decode(input logic [13:0] word);
    bba_decode_t d;
    d.op = OP_IDLE_SLOT;
    d.dest_file = word[`BBA_DEST_POS];
    d.bit_idx = word[`BBA_IDX_HI:`BBA_IDX_LO];
    d.addr = word[`BBA_ADDR_HI:`BBA_ADDR_LO];
    d.literal = word[`BBA_K_HI:`BBA_K_LO];
    case (word[`BBA_CLASS_HI:`BBA_CLASS_LO])
      `BBA_CLASS_BIT: begin
        case (word[`BBA_BSEL_HI:`BBA_BSEL_LO])
          `BBA_BSEL_CLR: d.op = OP_BIT_CLEAR;
          `BBA_BSEL_SET: d.op = OP_BIT_SET;
          `BBA_BSEL_SKC: d.op = OP_SKIP_IF_CLEAR;
          default: d.op = OP_SKIP_IF_SET;
        endcase
      end
      `BBA_CLASS_BYTE: begin
        if (word[`BBA_BYTE_OP_HI:`BBA_BYTE_OP_LO] == `BBA_BYTE_ADD) begin
          d.op = OP_ADD_FILE;
        end else if (word[`BBA_BYTE_OP_HI:`BBA_BYTE_OP_LO] == `BBA_BYTE_AND) begin
          d.op = OP_AND_FILE;
        end
      end
      `BBA_CLASS_LIT: begin
        if (word[`BBA_LIT_ADD_HI:`BBA_LIT_ADD_LO] == `BBA_LIT_ADD) begin
          d.op = OP_ADD_LITERAL;
        end else if (word[`BBA_BYTE_OP_HI:`BBA_BYTE_OP_LO] == `BBA_LIT_AND) begin
          d.op = OP_AND_LITERAL;
        end
      end
      default: d.op = OP_IDLE_SLOT;
    endcase
    return d;
  endfunction

  function automatic logic is_file_op(input bba_op_t op);
    return (op == OP_ADD_FILE) || (op == OP_AND_FILE);
  endfunction

  function automatic logic is_bit_write(input bba_op_t op);
    return (op == OP_BIT_CLEAR) || (op == OP_BIT_SET);
  endfunction

  ////////////////////////////////////////////////////////////
  // State
  logic [7:0] pin_meta_reg;
  logic [7:0] pin_sync_reg;
  logic [7:0] file_mem [0:127];
  logic [12:0] ptr_reg;
  logic [12:0] ptr_next;
  logic [7:0] w_reg;
  logic [7:0] w_next;
  bba_flags_t flags_reg;
  bba_flags_t flags_next;
  logic [7:0] port_reg;
  logic [7:0] port_next;
  logic presc_clr_reg;
  logic presc_clr_next;
  bba_slot_t slot_reg;
  bba_slot_t slot_next;
  logic idle_reg;

  ////////////////////////////////////////////////////////////
  // Datapath
  bba_decode_t dec;
  logic [7:0] alu_result;
  bba_flags_t alu_flags;
  logic alu_test;

  assign dec = decode(INSTR);

  wire running = (slot_reg == SLOT_RUN);
  wire is_port = (dec.addr == `BBA_ADDR_PORT);
  wire [7:0] file_rd = is_port ? pin_sync_reg : file_mem[dec.addr];
  wire file_op = is_file_op(dec.op);
  wire writes_file = running && (is_bit_write(dec.op) || (file_op && dec.dest_file));
  wire writes_w = running && ((dec.op == OP_ADD_LITERAL) || (dec.op == OP_AND_LITERAL) ||
                              (file_op && !dec.dest_file));
  wire flags_upd = running && (file_op || (dec.op == OP_ADD_LITERAL) || (dec.op == OP_AND_LITERAL));
  wire skip_taken = running && (((dec.op == OP_SKIP_IF_CLEAR) && !alu_test) ||
                                ((dec.op == OP_SKIP_IF_SET) && alu_test));
  wire ptr_write = writes_file && (dec.addr == `BBA_ADDR_PTR_LOW);
  wire timer_write = writes_file && (dec.addr == `BBA_ADDR_TIMER);

  bba_alu u_alu (
    .op(dec.op),
    .w_val(w_reg),
    .file_val(file_rd),
    .literal(dec.literal),
    .bit_idx(dec.bit_idx),
    .flags_in(flags_reg),
    .result(alu_result),
    .flags_out(alu_flags),
    .test_bit(alu_test)
  );

  assign slot_next = (skip_taken || ptr_write) ? SLOT_IDLE : SLOT_RUN;
  assign ptr_next = ptr_write ? {ptr_reg[12:8], alu_result} : ptr_reg + 13'h0001;
  assign w_next = writes_w ? alu_result : w_reg;
  assign flags_next = flags_upd ? alu_flags : flags_reg;
  assign port_next = (writes_file && is_port) ? alu_result : port_reg;
  assign presc_clr_next = timer_write && PRESC_ON_TIMER;

  ////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge CLK) begin
    pin_meta_reg <= PIN_IN;
    pin_sync_reg <= pin_meta_reg;
  end

  always_ff @(posedge CLK) begin
    if (writes_file) begin
      file_mem[dec.addr] <= alu_result;
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      ptr_reg <= `BBA_PTR_RESET;
      w_reg <= `BBA_W_RESET;
      flags_reg <= '0;
      port_reg <= `BBA_PORT_RESET;
      presc_clr_reg <= 1'b0;
      slot_reg <= SLOT_RUN;
      idle_reg <= 1'b0;
    end else begin
      ptr_reg <= ptr_next;
      w_reg <= w_next;
      flags_reg <= flags_next;
      port_reg <= port_next;
      presc_clr_reg <= presc_clr_next;
      slot_reg <= slot_next;
      idle_reg <= (slot_next == SLOT_IDLE);
    end
  end

  assign INSTR_ADDR = ptr_reg;
  assign W_OUT = w_reg;
  assign FLAGS = flags_reg;
  assign PORT_LATCH = port_reg;
  assign PRESC_CLR = presc_clr_reg;
  assign IDLE_SLOT = idle_reg;

  ////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RESET);

  port_read_pins_a: assert property (
    running && (dec.op == OP_AND_FILE) && is_port && !dec.dest_file
    |=> W_OUT == ($past(w_reg) & $past(pin_sync_reg)))
    else $error("port operand not taken from pins");

  presc_clear_a: assert property (
    timer_write && PRESC_ON_TIMER |=> PRESC_CLR)
    else $error("prescaler not cleared on timer write");

  presc_quiet_a: assert property (
    !(timer_write && PRESC_ON_TIMER) |=> !PRESC_CLR)
    else $error("prescaler cleared without timer write");

  two_cycle_a: assert property (
    skip_taken || ptr_write |=> IDLE_SLOT ##1 !IDLE_SLOT && $stable(W_OUT) && $stable(FLAGS))
    else $error("taken skip or pointer write did not idle one slot");

  ptr_advance_a: assert property (
    !ptr_write |=> INSTR_ADDR == $past(ptr_reg) + 13'h0001)
    else $error("instruction pointer did not advance");

  add_literal_a: assert property (
    running && (dec.op == OP_ADD_LITERAL)
    |=> W_OUT == ($past(w_reg) + $past(dec.literal)) &&
        FLAGS.carry == ({1'b0, $past(w_reg)} + {1'b0, $past(dec.literal)} > 9'h0ff))
    else $error("add literal result or carry wrong");

  bit_flags_a: assert property (
    running && is_bit_write(dec.op) |=> $stable(FLAGS) && $stable(W_OUT))
    else $error("bit operation changed flags or W");

  bit_result_a: assert property (
    writes_file && (dec.op == OP_BIT_SET) |-> alu_result[dec.bit_idx] &&
    ((alu_result | (8'h01 << dec.bit_idx)) == (file_rd | (8'h01 << dec.bit_idx))))
    else $error("bit set result wrong");

  dest_w_a: assert property (
    running && file_op && dec.dest_file |=> $stable(W_OUT))
    else $error("file destination changed W");

  and_zero_a: assert property (
    running && (dec.op == OP_AND_LITERAL)
    |=> FLAGS.zero == (W_OUT == 8'h00) && FLAGS.carry == $past(flags_reg.carry))
    else $error("and literal flags wrong");

  skip_clear_a: assert property (
    running && (dec.op == OP_SKIP_IF_CLEAR) && alu_test |=> !IDLE_SLOT)
    else $error("skip if clear skipped on a one");

  skip_set_a: assert property (
    running && (dec.op == OP_SKIP_IF_SET) |=> IDLE_SLOT == $past(alu_test))
    else $error("skip if set wrong");

  half_carry_a: assert property (
    running && (dec.op == OP_ADD_FILE)
    |=> FLAGS.half_carry_bit == ({1'b0, $past(w_reg[3:0])} + {1'b0, $past(file_rd[3:0])} > 5'h0f))
    else $error("half carry wrong");

endmodule // bba_core

// [bba_tb.sv]
`timescale 1ns/1ps

module testbench import bba_pkg::*; ();
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [13:0] instr = 14'h0000;
  logic [7:0] pin_in = 8'h5a;
  logic presc_on_timer = 1'b0;
  logic [12:0] instr_addr;
  logic [7:0] w_out;
  bba_flags_t flags;
  logic [7:0] port_latch;
  logic presc_clr;
  logic idle_slot;
  int failures = 0;
  int samples_checked = 0;
  int cycles = 0;

  bba_core uut (
    .CLK(clk),
    .RESET(reset),
    .INSTR(instr),
    .PIN_IN(pin_in),
    .PRESC_ON_TIMER(presc_on_timer),
    .INSTR_ADDR(instr_addr),
    .W_OUT(w_out),
    .FLAGS(flags),
    .PORT_LATCH(port_latch),
    .PRESC_CLR(presc_clr),
    .IDLE_SLOT(idle_slot)
  );

  ////////////////////////////////////////////////////////////
  // Helpers
  initial begin
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      tally_and_finish();
    end
  end

  task tally_and_finish();
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task chk(input logic [12:0] got, input logic [12:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  function logic [13:0] fop(input logic [3:0] op, input logic d, input logic [6:0] f);
    return {2'h0, op, d, f};
  endfunction

  function logic [13:0] bop(input logic [1:0] s, input logic [2:0] b, input logic [6:0] f);
    return {2'h1, s, b, f};
  endfunction

  task step(input logic [13:0] word);
    instr = word;
    @(posedge clk);
    #1;
  endtask

  task run(input logic [13:0] word, input logic [7:0] ew, input logic [2:0] ef);
    step(word);
    chk(w_out, ew);
    chk(flags, ef);
  endtask

  task setw(input logic [7:0] v);
    step({6'h39, 8'h00});
    step({6'h3e, v});
  endtask

  task setf(input logic [6:0] f, input logic [7:0] v);
    setw(8'h00);
    step(fop(4'h5, 1'b1, f));
    setw(v);
    step(fop(4'h7, 1'b1, f));
  endtask

  ////////////////////////////////////////////////////////////
  // Scenarios
  task t_reset();
    chk(w_out, 8'h00);
    chk(flags, 3'h0);
    chk(instr_addr, 13'h0000);
    chk(port_latch, 8'h00);
    chk({presc_clr, idle_slot}, 2'h0);
    $display("test reset done");
  endtask

  task t_literal();
    run({6'h3e, 8'h0f}, 8'h0f, 3'h0);
    run({6'h3f, 8'h01}, 8'h10, 3'h2);
    run({6'h3e, 8'hf0}, 8'h00, 3'h5);
    run({6'h3e, 8'h02}, 8'h02, 3'h0);
    run({6'h3e, 8'hff}, 8'h01, 3'h6);
    run({6'h39, 8'h03}, 8'h01, 3'h6);
    run({6'h39, 8'h02}, 8'h00, 3'h7);
    $display("test literal done");
  endtask

  task t_file();
    setf(7'h20, 8'h3c);
    setw(8'h0a);
    run(fop(4'h7, 1'b0, 7'h20), 8'h46, 3'h2);
    run(fop(4'h7, 1'b1, 7'h20), 8'h46, 3'h2);
    run(fop(4'h5, 1'b0, 7'h20), 8'h02, 3'h2);
    run(fop(4'h5, 1'b1, 7'h20), 8'h02, 3'h2);
    setw(8'h00);
    run(fop(4'h7, 1'b0, 7'h20), 8'h02, 3'h0);
    $display("test file done");
  endtask

  task t_bits();
    logic [1:0] sel [4];
    logic [2:0] bi [4];
    logic tk [4];
    logic [12:0] a;
    logic [7:0] ew;
    sel = '{2'h2, 2'h2, 2'h3, 2'h3};
    bi = '{3'h7, 3'h3, 3'h0, 3'h4};
    tk = '{1'b0, 1'b1, 1'b1, 1'b0};
    setf(7'h21, 8'h00);
    run(bop(2'h1, 3'h7, 7'h21), 8'h00, 3'h1);
    run(bop(2'h1, 3'h0, 7'h21), 8'h00, 3'h1);
    run(bop(2'h1, 3'h3, 7'h21), 8'h00, 3'h1);
    run(bop(2'h0, 3'h3, 7'h21), 8'h00, 3'h1);
    run(fop(4'h7, 1'b0, 7'h21), 8'h81, 3'h0);
    ew = 8'h81;
    for (int i = 0; i < 4; i++) begin
      a = instr_addr;
      step(bop(sel[i], bi[i], 7'h21));
      chk(idle_slot, tk[i]);
      step({6'h3e, 8'h01});
      if (!tk[i]) begin
        ew = ew + 8'h01;
      end
      chk(w_out, ew);
      chk(instr_addr, a + 13'h0002);
      chk(idle_slot, 1'b0);
    end
    $display("test bits done");
  endtask

  task t_port();
    setw(8'h00);
    step(fop(4'h5, 1'b1, 7'h05));
    chk(port_latch, 8'h00);
    step(bop(2'h1, 3'h0, 7'h05));
    chk(port_latch, 8'h5b);
    run(fop(4'h7, 1'b0, 7'h05), 8'h5a, 3'h0);
    $display("test port done");
  endtask

  task t_jump();
    setw(8'h00);
    step(fop(4'h5, 1'b1, 7'h02));
    chk(idle_slot, 1'b1);
    chk(instr_addr, 13'h0000);
    step({6'h3e, 8'h07});
    chk(idle_slot, 1'b0);
    chk(instr_addr, 13'h0001);
    chk(w_out, 8'h00);
    $display("test jump done");
  endtask

  task t_presc();
    presc_on_timer = 1'b1;
    step(fop(4'h5, 1'b1, 7'h01));
    chk(presc_clr, 1'b1);
    step({6'h39, 8'hff});
    chk(presc_clr, 1'b0);
    step(fop(4'h5, 1'b0, 7'h01));
    chk(presc_clr, 1'b0);
    step(bop(2'h1, 3'h0, 7'h01));
    chk(presc_clr, 1'b1);
    presc_on_timer = 1'b0;
    step(fop(4'h5, 1'b1, 7'h01));
    chk(presc_clr, 1'b0);
    $display("test prescaler done");
  endtask

  ////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (16) @(posedge clk);
    #1;
    reset = 1'b0;
    t_reset();
    t_literal();
    t_file();
    t_bits();
    t_port();
    t_jump();
    t_presc();
    tally_and_finish();
  end
endmodule // testbench
